//--- src/asa_consts.vh
`ifndef ASA_CONSTS_VH
`define ASA_CONSTS_VH
`define ASA_PICK_DATA 2'h0
`define ASA_PICK_STAT 2'h1
`define ASA_PICK_CMD 2'h2
`define ASA_PICK_CTL 2'h3
`define ASA_CMD_ENABLE 0
`define ASA_CMD_RTS_LO 2
`define ASA_CMD_RTS_HI 3
`define ASA_CMD_RTS_ON 2'h2
`define ASA_CMD_RXIRQ_DIS 1
`define ASA_CTL_RXCLK 4
`define ASA_CTL_WLEN_LO 5
`define ASA_CTL_WLEN_HI 6
`define ASA_CTL_STOP2 7
`define ASA_ST_PARITY 0
`define ASA_ST_FRAMING 1
`define ASA_ST_OVERRUN 2
`define ASA_ST_RXFULL 3
`define ASA_ST_TXEMPTY 4
`define ASA_ST_CARRIER 5
`define ASA_ST_SETREADY 6
`define ASA_ST_IRQ 7
`define ASA_CMD_RESET 8'h00
`define ASA_CTL_RESET 8'h00
`define ASA_CMD_SOFT_MASK 8'hE0
`define ASA_CMD_PAR_EN 5
`define ASA_CMD_PAR_ODD 6
`define ASA_XTAL_MHZ_X10K 18432
`define ASA_CLK_MHZ 25
`define ASA_OVS 16
`define ASA_OVS_MID 4'h7
`define ASA_EXT_PERIOD_NS 400
`define ASA_FIFO_DEPTH 16
`define ASA_FIFO_AW 4
`endif

//--- src/asa_fifo.v
`timescale 1ns/1ps
`default_nettype none
module asa_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
    if (reset) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // asa_fifo
`default_nettype wire

//--- src/asa_top.v
`timescale 1ns/1ps
`default_nettype none
`include "asa_consts.vh"
module asa_top (
  input wire clk_sys,
  input wire reset,
  input wire hardware_clear_n,
  input wire bus_phase_clock,
  input wire bus_read,
  input wire select_active_high,
  input wire select_active_low,
  input wire register_pick_lo,
  input wire register_pick_hi,
  input wire [7:0] parallel_bus_in,
  output reg [7:0] parallel_bus_out,
  output reg parallel_bus_oe,
  output reg irq_out,
  output reg irq_oe,
  input wire crystal_in,
  input wire receive_clock_16x_in,
  output reg receive_clock_16x_out,
  output reg receive_clock_16x_oe,
  output reg serial_out,
  input wire serial_in,
  output reg send_request_n,
  input wire clear_to_send_n,
  output reg terminal_ready_n,
  input wire set_ready_n,
  input wire carrier_present_n
);
  reg [7:0] cmd_r;
  reg [7:0] ctl_r;
  reg [7:0] rx_hold_r;
  reg rx_full_r, overrun_r, framing_r, parity_r, irq_r;
  reg err_arm_r;
  reg dsr_r, dcd_r, xtal_d_r, rxc_d_r, phase_d_r;
  reg [15:0] div_cnt_r;
  reg tick16_r;
  reg [3:0] tx_sub_r, rx_sub_r;
  reg [3:0] tx_bit_r, rx_bit_r;
  reg [10:0] tx_sh_r;
  reg tx_busy_r;
  reg [9:0] rx_sh_r;
  reg rx_busy_r;
  reg rx_s1_r, rx_s2_r;
  wire clr;
  wire sel;
  wire [1:0] pick;
  wire access;
  wire xtal_rise;
  wire rx_ext_tick;
  wire rx_tick;
  wire [15:0] divisor;
  wire f_valid, f_ready, f_out_valid;
  wire [7:0] f_out_data;
  wire f_pop;
  wire [3:0] wlen;
  wire [7:0] wmask;

  // single 25 MHz domain; bus clock and crystal are sampled as plain inputs
  function [15:0] baud_div;
    input [3:0] code;
    begin
      case (code)
        4'h1: baud_div = 16'h0900;
        4'h2: baud_div = 16'h0600;
        4'h3: baud_div = 16'h0417;
        4'h4: baud_div = 16'h0360;
        4'h5: baud_div = 16'h0180;
        4'h6: baud_div = 16'h00C0;
        4'h7: baud_div = 16'h0060;
        4'h8: baud_div = 16'h0040;
        4'h9: baud_div = 16'h0030;
        4'hA: baud_div = 16'h0020;
        4'hB: baud_div = 16'h0018;
        4'hC: baud_div = 16'h0010;
        4'hD: baud_div = 16'h000C;
        4'hE: baud_div = 16'h0008;
        4'hF: baud_div = 16'h0004;
        default: baud_div = 16'h0000;
      endcase
    end
  endfunction

  function parity_of;
    input [7:0] d;
    input [7:0] m;
    input odd;
    begin
      parity_of = ^(d & m) ^ odd;
    end
  endfunction

  assign clr = reset || !hardware_clear_n;
  assign sel = select_active_high && !select_active_low;
  assign pick = {register_pick_hi, register_pick_lo};
  assign access = sel && bus_phase_clock && !phase_d_r;
  assign xtal_rise = crystal_in && !xtal_d_r;
  assign rx_ext_tick = receive_clock_16x_in && !rxc_d_r;
  assign divisor = baud_div(ctl_r[3:0]);
  // code 0 means the crystal pin itself is the 16x clock
  assign rx_tick = ctl_r[`ASA_CTL_RXCLK] ? tick16_r : rx_ext_tick;
  assign wlen = 4'h8 - {2'h0, ctl_r[`ASA_CTL_WLEN_HI:`ASA_CTL_WLEN_LO]};
  assign wmask = 8'hFF >> ctl_r[`ASA_CTL_WLEN_HI:`ASA_CTL_WLEN_LO];
  assign f_valid = access && !bus_read && pick == `ASA_PICK_DATA;
  assign f_pop = f_out_valid && !tx_busy_r && !clear_to_send_n && tick16_r && tx_sub_r == 4'hF;

  asa_fifo #(.WIDTH(8), .DEPTH(`ASA_FIFO_DEPTH), .AW(`ASA_FIFO_AW)) u_fifo (
    .clk_sys(clk_sys),
    .reset(clr),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(parallel_bus_in),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  always @(posedge clk_sys) begin
    phase_d_r <= bus_phase_clock;
    xtal_d_r <= crystal_in;
    rxc_d_r <= receive_clock_16x_in;
    rx_s1_r <= serial_in;
    rx_s2_r <= rx_s1_r;
    if (clr) begin
      cmd_r <= `ASA_CMD_RESET;
      ctl_r <= `ASA_CTL_RESET;
      rx_hold_r <= 8'h00;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      parity_r <= 1'b0;
      irq_r <= 1'b0;
      err_arm_r <= 1'b0;
      dsr_r <= 1'b1;
      dcd_r <= 1'b1;
      div_cnt_r <= 16'h0000;
      tick16_r <= 1'b0;
      tx_sub_r <= 4'h0;
      rx_sub_r <= 4'h0;
      tx_bit_r <= 4'h0;
      rx_bit_r <= 4'h0;
      tx_sh_r <= 11'h7FF;
      tx_busy_r <= 1'b0;
      rx_sh_r <= 10'h000;
      rx_busy_r <= 1'b0;
      parallel_bus_out <= 8'h00;
      parallel_bus_oe <= 1'b0;
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
      receive_clock_16x_out <= 1'b0;
      receive_clock_16x_oe <= 1'b0;
      serial_out <= 1'b1;
      send_request_n <= 1'b1;
      terminal_ready_n <= 1'b1;
    end else begin
      // bus accesses first, so a flag event later in this cycle beats its clear-on-read
      parallel_bus_oe <= sel && bus_read && bus_phase_clock;
      if (access && bus_read) begin
        case (pick)
          `ASA_PICK_DATA: begin
            parallel_bus_out <= rx_hold_r;
            rx_full_r <= 1'b0;
            err_arm_r <= 1'b1;
          end
          `ASA_PICK_STAT: begin
            parallel_bus_out <= {irq_r, dsr_r, dcd_r, !tx_busy_r && !f_out_valid,
                                 rx_full_r, overrun_r, framing_r, parity_r};
            irq_r <= 1'b0;
          end
          `ASA_PICK_CMD: parallel_bus_out <= cmd_r;
          `ASA_PICK_CTL: parallel_bus_out <= ctl_r;
          default: parallel_bus_out <= 8'h00;
        endcase
      end else if (access && !bus_read) begin
        case (pick)
          `ASA_PICK_STAT: begin
            cmd_r <= cmd_r & `ASA_CMD_SOFT_MASK;
            overrun_r <= 1'b0;
          end
          `ASA_PICK_CMD: cmd_r <= parallel_bus_in;
          `ASA_PICK_CTL: ctl_r <= parallel_bus_in;
          default: cmd_r <= cmd_r;
        endcase
      end
      // baud generator off the sampled crystal edge
      tick16_r <= 1'b0;
      if (divisor == 16'h0000) begin
        tick16_r <= xtal_rise;
      end else if (xtal_rise) begin
        if (div_cnt_r >= divisor - 16'h0001) begin
          div_cnt_r <= 16'h0000;
          tick16_r <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 16'h0001;
        end
      end
      if (tick16_r) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      // transmitter; clear-to-send high stalls starts
      if (f_pop) begin
        tx_sh_r <= {2'h3, parity_of(f_out_data, wmask, cmd_r[`ASA_CMD_PAR_ODD]), f_out_data & wmask};
        tx_busy_r <= 1'b1;
        tx_bit_r <= 4'h0;
        serial_out <= 1'b0;
      end else if (tx_busy_r && tick16_r && tx_sub_r == 4'hF) begin
        if (tx_bit_r == wlen + {3'h0, cmd_r[`ASA_CMD_PAR_EN]} + {3'h0, ctl_r[`ASA_CTL_STOP2]}) begin
          tx_busy_r <= 1'b0;
          serial_out <= 1'b1;
        end else begin
          // parity slot driven high as a stop bit when disabled
          serial_out <= (tx_bit_r == wlen && !cmd_r[`ASA_CMD_PAR_EN]) ? 1'b1 :
                        (tx_bit_r < wlen ? tx_sh_r[tx_bit_r] : (tx_bit_r == wlen ? tx_sh_r[8] : 1'b1));
          tx_bit_r <= tx_bit_r + 4'h1;
        end
      end
      // receiver, gated by carrier
      if (carrier_present_n) begin
        rx_busy_r <= 1'b0;
      end else if (rx_tick) begin
        if (!rx_busy_r) begin
          if (!rx_s2_r) begin
            rx_busy_r <= 1'b1;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 4'h0;
          end
        end else begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == `ASA_OVS_MID) begin
            if (rx_bit_r == 4'h0 && rx_s2_r) begin
              rx_busy_r <= 1'b0; // false start
            end else if (rx_bit_r == wlen + {3'h0, cmd_r[`ASA_CMD_PAR_EN]} + 4'h1) begin
              rx_busy_r <= 1'b0;
              rx_hold_r <= rx_sh_r[7:0] & wmask;
              rx_full_r <= 1'b1;
              // old errors stay until a data read is followed by the next character, or for overrun until a status write
              overrun_r <= rx_full_r || (overrun_r && !err_arm_r);
              framing_r <= !rx_s2_r || (framing_r && !err_arm_r);
              parity_r <= (cmd_r[`ASA_CMD_PAR_EN] &&
                (parity_of(rx_sh_r[7:0], wmask, cmd_r[`ASA_CMD_PAR_ODD]) != rx_sh_r[8])) ||
                (parity_r && !err_arm_r);
              if (!rx_full_r && !cmd_r[`ASA_CMD_RXIRQ_DIS]) begin
                irq_r <= 1'b1;
              end
              if (err_arm_r) begin
                err_arm_r <= 1'b0;
              end
            end else begin
              if (rx_bit_r != 4'h0) begin
                if (rx_bit_r <= wlen) begin
                  rx_sh_r[rx_bit_r - 4'h1] <= rx_s2_r;
                end else begin
                  rx_sh_r[8] <= rx_s2_r;
                end
              end
              rx_bit_r <= rx_bit_r + 4'h1;
            end
          end
        end
      end
      // modem status change
      dsr_r <= set_ready_n;
      dcd_r <= carrier_present_n;
      if (cmd_r[`ASA_CMD_ENABLE] && (dsr_r != set_ready_n || dcd_r != carrier_present_n)) begin
        irq_r <= 1'b1;
      end
      if (err_arm_r && rx_full_r && !overrun_r && !framing_r && !parity_r) begin
        err_arm_r <= 1'b0;
      end
      irq_out <= 1'b0;
      irq_oe <= irq_r;
      receive_clock_16x_oe <= ctl_r[`ASA_CTL_RXCLK];
      receive_clock_16x_out <= tick16_r ? !receive_clock_16x_out : receive_clock_16x_out;
      send_request_n <= cmd_r[`ASA_CMD_RTS_HI:`ASA_CMD_RTS_LO] == 2'h0;
      terminal_ready_n <= !cmd_r[`ASA_CMD_ENABLE];
    end
  end
endmodule // asa_top
`default_nettype wire

//--- verif/asa_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asa_modem_model (
  input wire logic crystal_in,
  input wire logic serial_out,
  output var logic serial_in,
  output var logic clear_to_send_n,
  output var logic set_ready_n,
  output var logic carrier_present_n
);
  int wlen = 8;
  int rx_count = 0;
  logic [7:0] rx_byte = 8'h00;
  initial begin
    serial_in = 1'b1;
    clear_to_send_n = 1'b0;
    set_ready_n = 1'b1;
    carrier_present_n = 1'b0;
  end
  // mid-bit sampling, sixteen crystal ticks a bit
  always begin
    @(negedge serial_out);
    rx_byte = 8'h00;
    repeat (8) @(posedge crystal_in);
    for (int i = 0; i < wlen; i++) begin
      repeat (16) @(posedge crystal_in);
      rx_byte[i] = serial_out;
    end
    repeat (16) @(posedge crystal_in);
    rx_count++;
  end
  task automatic send(input logic [7:0] d);
    serial_in = 1'b0;
    repeat (16) @(posedge crystal_in);
    for (int i = 0; i < wlen; i++) begin
      serial_in = d[i];
      repeat (16) @(posedge crystal_in);
    end
    serial_in = 1'b1;
    repeat (16) @(posedge crystal_in);
  endtask
endmodule // asa_modem_model
`default_nettype wire

//--- verif/asa_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asa_top_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hardware_clear_n,
  input wire logic bus_phase_clock,
  input wire logic bus_read,
  input wire logic select_active_high,
  input wire logic select_active_low,
  input wire logic [7:0] parallel_bus_out,
  input wire logic parallel_bus_oe,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic receive_clock_16x_oe,
  input wire logic serial_out,
  input wire logic send_request_n,
  input wire logic clear_to_send_n,
  input wire logic terminal_ready_n,
  input wire logic set_ready_n,
  input wire logic carrier_present_n
);
  localparam int TX_DRAIN = 2000;
  wire logic rd_cyc = bus_phase_clock && bus_read && select_active_high && !select_active_low;
  logic [10:0] cts_hi_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a frame in flight may finish; this span covers the longest one at divisor 0
  always @(posedge clk_sys) begin
    if (reset || !clear_to_send_n) begin
      cts_hi_r <= 11'h000;
    end else if (cts_hi_r != 11'h7FF) begin
      cts_hi_r <= cts_hi_r + 11'h001;
    end
  end
  bus_oe_gate_a: assert property (parallel_bus_oe |-> $past(rd_cyc))
    else $error("bus driven outside read");
  bus_oe_drive_a: assert property ($past(rd_cyc) && $past(hardware_clear_n) && !$past(reset) |-> parallel_bus_oe)
    else $error("selected read not driven");
  irq_pull_a: assert property (irq_oe |-> !irq_out)
    else $error("irq not pulled low");
  clear_quiet_a: assert property (!hardware_clear_n |=> !parallel_bus_oe && !irq_oe && serial_out && send_request_n
    && terminal_ready_n && !receive_clock_16x_oe)
    else $error("clear left outputs active");
  dsr_irq_a: assert property (!terminal_ready_n && hardware_clear_n && $changed(set_ready_n) |-> ##[1:6] irq_oe)
    else $error("set-ready change no irq");
  dcd_irq_a: assert property (!terminal_ready_n && hardware_clear_n && $changed(carrier_present_n) |-> ##[1:6] irq_oe)
    else $error("carrier change no irq");
  cts_hold_a: assert property (cts_hi_r > TX_DRAIN |-> serial_out)
    else $error("sending while blocked");
  bus_out_hold_a: assert property ($changed(parallel_bus_out) |-> $past(bus_read) || $past(bus_read, 2)
    || !$past(hardware_clear_n))
    else $error("read data moved without read");
  read_c: cover property ($rose(parallel_bus_oe));
  irq_c: cover property ($rose(irq_oe));
  stall_c: cover property (cts_hi_r > TX_DRAIN);
endmodule // asa_top_asserts
bind asa_top asa_top_asserts u_chk (.clk_sys, .reset, .hardware_clear_n, .bus_phase_clock, .bus_read,
  .select_active_high, .select_active_low, .parallel_bus_out, .parallel_bus_oe, .irq_out, .irq_oe,
  .receive_clock_16x_oe, .serial_out, .send_request_n, .clear_to_send_n, .terminal_ready_n, .set_ready_n,
  .carrier_present_n);
`default_nettype wire

//--- verif/asa_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module asa_top_bench;
  logic clk_sys = 1'b0, reset = 1'b1, hardware_clear_n = 1'b1, bus_phase_clock = 1'b0, bus_read = 1'b1;
  logic select_active_high = 1'b0, select_active_low = 1'b1, register_pick_lo = 1'b0, register_pick_hi = 1'b0;
  logic crystal_in = 1'b0;
  logic [7:0] bus_drv = 8'h00, rb;
  wire [7:0] parallel_bus_out;
  wire parallel_bus_oe, irq_out, irq_oe, receive_clock_16x_out, receive_clock_16x_oe, serial_out, serial_in;
  wire send_request_n, clear_to_send_n, terminal_ready_n, set_ready_n, carrier_present_n;
  wire [7:0] dbus = parallel_bus_oe ? parallel_bus_out : bus_drv;
  wire irq_n = irq_oe ? irq_out : 1'b1;
  wire receive_clock_16x = receive_clock_16x_oe ? receive_clock_16x_out : crystal_in;
  int miscompares = 0, samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  // 400 ns, the shortest external clock period allowed
  always #200 crystal_in = ~crystal_in;
  asa_top dut (.clk_sys, .reset, .hardware_clear_n, .bus_phase_clock, .bus_read, .select_active_high,
    .select_active_low, .register_pick_lo, .register_pick_hi, .parallel_bus_in(dbus), .parallel_bus_out,
    .parallel_bus_oe, .irq_out, .irq_oe, .crystal_in, .receive_clock_16x_in(receive_clock_16x), .receive_clock_16x_out,
    .receive_clock_16x_oe, .serial_out, .serial_in, .send_request_n, .clear_to_send_n, .terminal_ready_n,
    .set_ready_n, .carrier_present_n);
  asa_modem_model modem (.crystal_in, .serial_out, .serial_in, .clear_to_send_n, .set_ready_n,
    .carrier_present_n);
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access per phase pulse; everything held until read data is taken
  task automatic acc(input logic sh, input logic sl, input logic rd, input logic [1:0] pk, input logic [7:0] wd);
    @(posedge clk_sys);
    {select_active_high, select_active_low, bus_read, register_pick_hi, register_pick_lo} <= {sh, sl, rd, pk};
    bus_drv <= wd;
    @(posedge clk_sys);
    bus_phase_clock <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rb = parallel_bus_out;
    bus_phase_clock <= 1'b0;
    @(posedge clk_sys);
    {select_active_high, select_active_low} <= 2'b01;
  endtask
  task automatic wait_tx(input int n);
    for (int k = 0; k < 30000 && modem.rx_count < n; k++) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    acc(1, 0, 1, 2'h1, 8'h00);
    chk("status", 8'h10, rb & 8'h9F);
    chk("dtr", 8'h01, {7'h00, terminal_ready_n});
    chk("rts", 8'h01, {7'h00, send_request_n});
  endtask
  task automatic t_regs;
    acc(1, 0, 0, 2'h2, 8'h09);
    acc(1, 0, 0, 2'h3, 8'h10);
    acc(0, 0, 0, 2'h3, 8'hFF);
    acc(1, 1, 0, 2'h3, 8'hFF);
    acc(1, 0, 1, 2'h3, 8'h00);
    chk("ctl", 8'h10, rb);
    acc(1, 0, 1, 2'h2, 8'h00);
    chk("cmd", 8'h09, rb);
    chk("dtr", 8'h00, {7'h00, terminal_ready_n});
    chk("rts", 8'h00, {7'h00, send_request_n});
    chk("rxc oe", 8'h01, {7'h00, receive_clock_16x_oe});
    rb = {7'h00, receive_clock_16x_out};
    repeat (10) @(posedge clk_sys);
    chk("rxc out", rb ^ 8'h01, {7'h00, receive_clock_16x_out});
  endtask
  task automatic t_soft;
    acc(1, 0, 0, 2'h2, 8'hE9);
    acc(1, 0, 0, 2'h1, 8'hFF);
    acc(1, 0, 1, 2'h2, 8'h00);
    chk("cmd soft", 8'hE0, rb);
    @(posedge clk_sys);
    hardware_clear_n <= 1'b0;
    @(posedge clk_sys);
    hardware_clear_n <= 1'b1;
    acc(1, 0, 1, 2'h3, 8'h00);
    chk("ctl clear", 8'h00, rb);
    chk("rxc oe", 8'h00, {7'h00, receive_clock_16x_oe});
    acc(1, 0, 0, 2'h3, 8'h10);
    acc(1, 0, 0, 2'h2, 8'h01);
  endtask
  task automatic t_tx;
    int n;
    n = modem.rx_count;
    acc(1, 0, 0, 2'h0, 8'hA5);
    wait_tx(n + 1);
    chk("tx byte", 8'hA5, modem.rx_byte);
    acc(1, 0, 0, 2'h3, 8'h30);
    modem.wlen = 7;
    acc(1, 0, 0, 2'h0, 8'hC5);
    wait_tx(n + 2);
    chk("tx short", 8'h45, modem.rx_byte);
  endtask
  task automatic t_fifo;
    int n;
    acc(1, 0, 0, 2'h3, 8'h10);
    modem.wlen = 8;
    modem.clear_to_send_n <= 1'b1;
    n = modem.rx_count;
    for (int i = 0; i < 17; i++) acc(1, 0, 0, 2'h0, 8'h40 + 8'(i));
    repeat (2500) @(posedge clk_sys);
    chk("stalled", 8'h00, 8'(modem.rx_count - n));
    modem.clear_to_send_n <= 1'b0;
    wait_tx(n + 16);
    repeat (1000) @(posedge clk_sys);
    chk("sent", 8'h10, 8'(modem.rx_count - n));
    chk("last", 8'h4F, modem.rx_byte);
  endtask
  task automatic t_rx;
    modem.send(8'h3C);
    repeat (8) @(posedge clk_sys);
    acc(1, 0, 1, 2'h1, 8'h00);
    chk("rx full", 8'h08, rb & 8'h0F);
    acc(1, 0, 1, 2'h0, 8'h00);
    chk("rx byte", 8'h3C, rb);
    acc(1, 0, 0, 2'h3, 8'h30);
    modem.wlen = 7;
    modem.send(8'hFF);
    repeat (8) @(posedge clk_sys);
    acc(1, 0, 1, 2'h0, 8'h00);
    chk("rx short", 8'h7F, rb);
    acc(1, 0, 0, 2'h3, 8'h00);
    modem.wlen = 8;
    modem.send(8'hA6);
    repeat (8) @(posedge clk_sys);
    acc(1, 0, 1, 2'h0, 8'h00);
    chk("rx ext", 8'hA6, rb);
    acc(1, 0, 0, 2'h3, 8'h10);
    modem.wlen = 8;
  endtask
  task automatic t_irq;
    acc(1, 0, 1, 2'h1, 8'h00);
    modem.set_ready_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("irq low", 8'h00, {7'h00, irq_n});
    acc(1, 0, 1, 2'h1, 8'h00);
    chk("dsr stat", 8'h80, rb & 8'hC0);
    chk("irq high", 8'h01, {7'h00, irq_n});
    modem.carrier_present_n <= 1'b1;
    modem.send(8'h55);
    repeat (8) @(posedge clk_sys);
    acc(1, 0, 1, 2'h1, 8'h00);
    chk("dcd stat", 8'hA0, rb & 8'hE8);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_soft;
    t_tx;
    t_fifo;
    t_rx;
    t_irq;
    close_out;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    close_out;
  end
endmodule // asa_top_bench
`default_nettype wire
